// [core/alu_flags_pkg.sv]
// Purpose: types shared by the flag datapath modules
// Assumes: nothing
// Notes:   numbers live in alu_flags_regs.svh
package alu_flags_pkg;

  // instruction classes seen by the flag logic
  typedef enum logic [3:0]
  {
    op_add_register,
    op_add_literal,
    op_subtract_from_literal,
    op_subtract_register,
    op_rotate_right,
    op_rotate_left,
    op_clear_file,
    op_bit_clear,
    op_bit_set,
    op_nibble_swap,
    op_file_to_file_move,
    op_work_to_file_move,
    op_and,
    op_or,
    op_xor,
    op_move_file
  } op_t;

endpackage

// [core/alu_flags_regs.svh]
// Purpose: offsets, bit positions and reset values of the ALU flag register
// Assumes: 12-bit data address space, 8-bit data
// Notes:   definitions only
`ifndef ALU_FLAGS_REGS_SVH
`define ALU_FLAGS_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FLAGS_ADDR       12'hFDB
`define LAST_RESULT_ADDR 12'hFDA

// ----------------------------------------------------------------
// flag field positions
// ----------------------------------------------------------------
`define FLAG_C_BIT       0
`define FLAG_DC_BIT      1
`define FLAG_Z_BIT       2
`define FLAG_OV_BIT      3
`define FLAG_N_BIT       4
`define FLAG_COUNT       5
`define FLAG_ALL_MASK    5'h1F
`define FLAG_NZ_MASK     5'h14
`define FLAG_Z_MASK      5'h04
`define FLAG_NONE_MASK   5'h00

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FLAGS_RESET      5'h00
`define RESULT_RESET     8'h00

`endif

// [core/alu_status_flags.sv]
// Purpose: arithmetic flag register of an 8-bit core and its update logic
// Assumes: one instruction per cycle presented by the datapath
// Notes:   flags reset to zero; result leaves one cycle after the issue
//
// What this block does
// - Flag register is an ordinary register, usable as source or destination.
// - Flag-updating instruction targeting flag register: data write blocked, ALU flags win.
// - Clearing the flag register sets zero, keeps other four flags.
// - Bit clear/set, swap, file-to-file and w-to-file moves change the five flags only when the flag register is their destination.
// - Bits 7 to 5 read zero and ignore writes.
// - Negative flag (bit 4) follows result msb.
// - Overflow flag (bit 3) set when signed result flips sign bit.
// - Zero flag (bit 2) set when result is zero.
// - Digit carry (bit 1) is carry out of bit 3 for add/sub.
// - Carry (bit 0) is carry out of msb for add/sub.
// - Subtraction adds two's complement, so carries mean no borrow.
// - Rotates load digit carry from bit 4/3, carry from end bit.
`timescale 1ns/100ps
`include "alu_flags_regs.svh"
module alu_status_flags
  import alu_flags_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // instruction issue
  input  wire logic              instr_valid,
  input  wire op_t               instr_op,
  input  wire logic [DATA_W-1:0] operand_w,
  input  wire logic [DATA_W-1:0] operand_f,
  input  wire logic [2:0]        bit_sel,
  input  wire logic              dest_is_file,
  input  wire logic [ADDR_W-1:0] dest_addr,
  // instruction result
  output logic                   result_valid_q,
  output logic      [DATA_W-1:0] result_q,
  output logic                   result_to_file_q,
  output logic      [ADDR_W-1:0] result_addr_q,
  // flag register as a source operand
  output logic      [DATA_W-1:0] flags_value,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int NF = `FLAG_COUNT;

  flag_calc_if fc ();

  logic [NF-1:0]     flags_q;
  logic [NF-1:0]     flags_d;
  logic [DATA_W-1:0] last_result_q;
  logic [DATA_W-1:0] rdata_q;
  logic              instr_hits_flags;
  logic              bus_wr_flags;
  logic              bus_wr_last;
  logic              bus_rd_flags;
  logic              bus_rd_last;
  logic [DATA_W-1:0] rdata_d;

  // ----------------------------------------------------------------
  // flag calculator
  // ----------------------------------------------------------------

  // operands straight from the issue port, carry in from the flag register
  assign fc.op       = instr_op;
  assign fc.w_val    = operand_w;
  assign fc.f_val    = operand_f;
  assign fc.bit_sel  = bit_sel;
  assign fc.carry_in = flags_q[`FLAG_C_BIT];

  flag_calc u_calc
  (
    .fc (fc.calc)
  );

  // ----------------------------------------------------------------
  // destination decode
  // ----------------------------------------------------------------

  assign instr_hits_flags = instr_valid & dest_is_file & (dest_addr == `FLAGS_ADDR);

  // register port decode
  always_comb
  begin
    bus_wr_flags = 1'b0;
    bus_wr_last  = 1'b0;
    bus_rd_flags = 1'b0;
    bus_rd_last  = 1'b0;
    if (reg_addr == `FLAGS_ADDR)
    begin
      bus_wr_flags = reg_wr;
      bus_rd_flags = reg_rd;
    end
    else if (reg_addr == `LAST_RESULT_ADDR)
    begin
      bus_wr_last = reg_wr;
      bus_rd_last = reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // per-flag next value
  // ----------------------------------------------------------------

  // priority low to high: hold, bus write, instruction data, ALU flag
  generate
    for (genvar i = 0; i < NF; i++)
    begin : g_flag
      logic data_wr;
      logic alu_wr;

      // data write only for no-flag ops
      assign data_wr = instr_hits_flags & (fc.flags_mask == `FLAG_NONE_MASK);
      assign alu_wr  = instr_valid & fc.flags_mask[i];

      assign flags_d[i] = alu_wr       ? fc.flags_new[i] :
                          data_wr      ? fc.result[i]    :
                          bus_wr_flags ? reg_wdata[i]    :
                                         flags_q[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag register
  // ----------------------------------------------------------------

  // five stored bits only; upper bits have no storage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flags_q <= `FLAGS_RESET;
    else
      flags_q <= flags_d;
  end

  assign flags_value = {{(DATA_W-NF){1'b0}}, flags_q};

  // ----------------------------------------------------------------
  // instruction result
  // ----------------------------------------------------------------

  // result presented the cycle after issue
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      result_valid_q   <= 1'b0;
      result_q         <= `RESULT_RESET;
      result_to_file_q <= 1'b0;
      result_addr_q    <= '0;
    end
    else
    begin
      result_valid_q <= instr_valid;
      if (instr_valid)
      begin
        result_q         <= fc.result;
        result_to_file_q <= dest_is_file;
        result_addr_q    <= dest_addr;
      end
    end
  end

  // last result, also writable for test access
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      last_result_q <= `RESULT_RESET;
    else if (instr_valid)
      last_result_q <= fc.result;
    else if (bus_wr_last)
      last_result_q <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------

  // unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    if (bus_rd_flags)
      rdata_d = flags_value;
    else if (bus_rd_last)
      rdata_d = last_result_q;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

endmodule

// [core/flag_calc.sv]
// Purpose: computes an instruction result and its arithmetic flags
// Assumes: operands steady for the cycle
// Notes:   combinational only
`timescale 1ns/100ps
`include "alu_flags_regs.svh"
module flag_calc
  import alu_flags_pkg::*;
(
  // operands and answer
  flag_calc_if.calc fc
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic       arith;

  // subtraction adds the two's complement of w
  always_comb
  begin
    arith   = 1'b0;
    addend  = fc.w_val;
    case (fc.op)
      op_add_register, op_add_literal: arith = 1'b1;
      op_subtract_from_literal, op_subtract_register:
      begin
        arith  = 1'b1;
        addend = ~fc.w_val;
      end
      default: arith = 1'b0;
    endcase
    sum     = {1'b0, fc.f_val} + {1'b0, addend} + {8'h00, (addend != fc.w_val)};
    low_sum = {1'b0, fc.f_val[3:0]} + {1'b0, addend[3:0]} + {4'h0, (addend != fc.w_val)};
  end

  // result and update mask per class
  always_comb
  begin
    fc.result     = fc.f_val;
    fc.flags_mask = `FLAG_NONE_MASK;
    fc.flags_new  = `FLAGS_RESET;
    case (fc.op)
      op_add_register, op_add_literal, op_subtract_from_literal, op_subtract_register:
      begin
        fc.result     = sum[7:0];
        fc.flags_mask = `FLAG_ALL_MASK;
      end
      op_rotate_right:
      begin
        fc.result     = {fc.carry_in, fc.f_val[7:1]};
        fc.flags_mask = `FLAG_ALL_MASK & ~(5'h01 << `FLAG_OV_BIT);
      end
      op_rotate_left:
      begin
        fc.result     = {fc.f_val[6:0], fc.carry_in};
        fc.flags_mask = `FLAG_ALL_MASK & ~(5'h01 << `FLAG_OV_BIT);
      end
      op_clear_file:
      begin
        fc.result     = 8'h00;
        fc.flags_mask = `FLAG_Z_MASK;
      end
      op_bit_clear: fc.result = fc.f_val & ~(8'h01 << fc.bit_sel);
      op_bit_set:   fc.result = fc.f_val | (8'h01 << fc.bit_sel);
      op_nibble_swap: fc.result = {fc.f_val[3:0], fc.f_val[7:4]};
      op_work_to_file_move: fc.result = fc.w_val;
      op_and: fc.result = fc.f_val & fc.w_val;
      op_or:  fc.result = fc.f_val | fc.w_val;
      op_xor: fc.result = fc.f_val ^ fc.w_val;
      op_move_file:
      begin
        fc.result     = fc.f_val;
        fc.flags_mask = `FLAG_NZ_MASK;
      end
      default: fc.result = fc.f_val;
    endcase
    if (fc.op == op_and || fc.op == op_or || fc.op == op_xor)
      fc.flags_mask = `FLAG_NZ_MASK;
    fc.flags_new[`FLAG_N_BIT]  = fc.result[7];
    fc.flags_new[`FLAG_Z_BIT]  = (fc.result == 8'h00);
    fc.flags_new[`FLAG_OV_BIT] = arith & (fc.f_val[7] == addend[7]) & (sum[7] != fc.f_val[7]);
    fc.flags_new[`FLAG_DC_BIT] = low_sum[4];
    fc.flags_new[`FLAG_C_BIT]  = sum[8];
    if (fc.op == op_rotate_right)
    begin
      fc.flags_new[`FLAG_DC_BIT] = fc.f_val[4];
      fc.flags_new[`FLAG_C_BIT]  = fc.f_val[0];
    end
    else if (fc.op == op_rotate_left)
    begin
      fc.flags_new[`FLAG_DC_BIT] = fc.f_val[3];
      fc.flags_new[`FLAG_C_BIT]  = fc.f_val[7];
    end
  end

endmodule

// [core/flag_calc_if.sv]
// Purpose: operands in, result and flag update out, for the flag calculator
// Assumes: purely combinational path
// Notes:   one modport per side
`timescale 1ns/100ps
interface flag_calc_if;
  import alu_flags_pkg::*;

  op_t        op;
  logic [7:0] w_val;
  logic [7:0] f_val;
  logic [2:0] bit_sel;
  logic       carry_in;
  logic [7:0] result;
  logic [4:0] flags_new;
  logic [4:0] flags_mask;

  modport core
  (
    output op, w_val, f_val, bit_sel, carry_in,
    input  result, flags_new, flags_mask
  );

  modport calc
  (
    input  op, w_val, f_val, bit_sel, carry_in,
    output result, flags_new, flags_mask
  );
endinterface

// [test/alu_status_flags_chk.sv]
// Purpose: port assertions for the flag register
// Assumes: one clock, reset high is active
// Notes:   bound into alu_status_flags
`timescale 1ns/100ps
`include "alu_flags_regs.svh"
module alu_status_flags_chk
  import alu_flags_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // instruction side
  input wire logic        instr_valid,
  input wire op_t         instr_op,
  input wire logic [7:0]  operand_w,
  input wire logic [7:0]  operand_f,
  input wire logic        dest_is_file,
  input wire logic [11:0] dest_addr,
  input wire logic        result_valid_q,
  input wire logic [7:0]  result_q,
  input wire logic [7:0]  flags_value,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata
);
  // --------------------------------
  // checks
  // --------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // bus write to the flags, loses to instruction flag updates and instruction data writes to the flags
  wire bus_hit = reg_wr && reg_addr == `FLAGS_ADDR;
  wire to_flags = dest_is_file && dest_addr == `FLAGS_ADDR;

  // flag register read strobe
  wire rd_flags = reg_rd && reg_addr == `FLAGS_ADDR;

  AST_RES_VALID: assert property (instr_valid |=> result_valid_q)
    else $error("result valid missing");
  AST_HI_ZERO: assert property (flags_value[7:5] == 3'h0
    && (!$past(rd_flags) || reg_rdata[7:5] == 3'h0))
    else $error("upper flag bits not zero");
  AST_NEG: assert property (result_valid_q
    && ($past(instr_op) < op_clear_file || $past(instr_op) > op_work_to_file_move)
    |-> flags_value[4] == result_q[7])
    else $error("negative flag wrong");
  AST_ZERO: assert property (result_valid_q
    && !($past(instr_op) inside {[op_bit_clear:op_work_to_file_move]})
    |-> flags_value[2] == (result_q == 8'h00))
    else $error("zero flag wrong");
  AST_HOLD: assert property (instr_valid && !to_flags && !bus_hit
    && instr_op inside {[op_bit_clear:op_work_to_file_move]} |=> $stable(flags_value))
    else $error("flags moved on a no-flag op");
  AST_CLEAR: assert property (instr_valid && instr_op == op_clear_file && !bus_hit
    |=> flags_value == ($past(flags_value) | 8'h04))
    else $error("clear did not set only zero");
  AST_ADD: assert property (instr_valid && instr_op == op_add_register
    |=> {flags_value[0], result_q} == $past({1'b0, operand_f} + {1'b0, operand_w})
    && flags_value[1] == $past(operand_f[3:0] + operand_w[3:0] > 5'h0F))
    else $error("add carry wrong");
  AST_SUB: assert property (instr_valid && instr_op == op_subtract_register
    |=> flags_value[0] == $past(operand_f >= operand_w))
    else $error("borrow polarity wrong");
  AST_ROT: assert property (instr_valid && instr_op == op_rotate_right
    |=> flags_value[1:0] == $past({operand_f[4], operand_f[0]})
    && result_q == $past({flags_value[0], operand_f[7:1]}))
    else $error("rotate flags wrong");
  AST_READ: assert property (rd_flags && !instr_valid
    |=> reg_rdata == flags_value)
    else $error("flag read mismatch");
endmodule

bind alu_status_flags alu_status_flags_chk i_alu_status_flags_chk
(
  .clk, .reset, .instr_valid, .instr_op, .operand_w, .operand_f, .dest_is_file,
  .dest_addr, .result_valid_q, .result_q, .flags_value, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata
);

// [test/tb_alu_status_flags.sv]
// Purpose: directed test of the ALU flag register
// Assumes: 40 MHz clock, reset high for 12 cycles
// Notes:   flags seen on the port and by register read
`timescale 1ns/100ps
`include "alu_flags_regs.svh"
module tb_alu_status_flags
  import alu_flags_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        instr_valid = 1'b0;
  op_t         instr_op = op_and;
  logic [7:0]  operand_w = 8'h00;
  logic [7:0]  operand_f = 8'h00;
  logic [2:0]  bit_sel = 3'h3;
  logic        dest_is_file = 1'b0;
  logic [11:0] dest_addr = `FLAGS_ADDR;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        result_valid_q;
  logic [7:0]  result_q;
  logic        result_to_file_q;
  logic [11:0] result_addr_q;
  logic [7:0]  flags_value;
  logic [7:0]  reg_rdata;
  int          bad_count = 0;
  int          cmp_count = 0;
  // op table: operands, expected result and flags
  op_t         ops[17] = '{op_add_register, op_add_literal, op_subtract_register,
    op_subtract_register, op_subtract_from_literal, op_xor, op_rotate_left,
    op_rotate_right, op_bit_set, op_bit_clear, op_nibble_swap,
    op_file_to_file_move, op_work_to_file_move, op_and, op_or, op_clear_file,
    op_move_file};
  logic [7:0]  fs[17] = '{8'h7F, 8'hFF, 8'h05, 8'h00, 8'h80, 8'hAA, 8'h81, 8'h10,
    8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h80, 8'h55, 8'h00};
  logic [7:0]  ws[17] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'hAA, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h01, 8'h00, 8'h00};
  logic [7:0]  rs[17] = '{8'h80, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'h00, 8'h03, 8'h88,
    8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h00, 8'h00};
  logic [7:0]  fl[17] = '{8'h1A, 8'h07, 8'h07, 8'h10, 8'h09, 8'h0D, 8'h09, 8'h1A,
    8'h1A, 8'h1A, 8'h1A, 8'h1A, 8'h1A, 8'h0E, 8'h1A, 8'h1E, 8'h0E};

  alu_status_flags i_alu_status_flags
  (
    .clk, .reset, .instr_valid, .instr_op, .operand_w, .operand_f, .bit_sel,
    .dest_is_file, .dest_addr, .result_valid_q, .result_q, .result_to_file_q,
    .result_addr_q, .flags_value, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata
  );

  // 25 ns clock
  always #12.5 clk = ~clk;

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle bus write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // bus read, data in the next cycle only
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // issue one instruction, dst picks the flag register
  task automatic run(input op_t op, input logic [7:0] f, w, input logic dst);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    operand_f <= f;
    operand_w <= w;
    dest_is_file <= dst;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // verdict and stop
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #(25 * 5000);
    bad_count++;
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(`FLAGS_ADDR, 8'h00);
    wr(`FLAGS_ADDR, 8'hFF);
    rd(`FLAGS_ADDR, 8'h1F);
    rd(12'h123, 8'h00);
    $display("test register access done");
    for (int i = 0; i < 17; i++)
    begin
      run(ops[i], fs[i], ws[i], 1'b0);
      chk(result_q, rs[i]);
      chk(flags_value, fl[i]);
      chk({7'h00, result_to_file_q}, 8'h00);
    end
    $display("test flag table done");
    wr(`FLAGS_ADDR, 8'h13);
    run(op_clear_file, 8'h55, 8'h00, 1'b1);
    chk(flags_value, 8'h17);
    chk({3'h0, result_to_file_q, result_addr_q[11:8]}, 8'h1F);
    chk(result_addr_q[7:0], 8'hDB);
    run(op_add_register, 8'h7F, 8'h01, 1'b1);
    rd(`FLAGS_ADDR, 8'h1A);
    run(op_work_to_file_move, 8'h00, 8'hFF, 1'b1);
    chk(flags_value, 8'h1F);
    run(op_nibble_swap, 8'h21, 8'h00, 1'b1);
    chk(flags_value, 8'h12);
    rd(`LAST_RESULT_ADDR, 8'h12);
    wr(`LAST_RESULT_ADDR, 8'hA5);
    rd(`LAST_RESULT_ADDR, 8'hA5);
    rd(`FLAGS_ADDR, 8'h12);
    $display("test flag destination done");
    end_sim();
  end
endmodule
